// ---- design/fsps_pkg.sv ----
/*
  Package for the flash self-program sequencer: register offsets, field
  positions, reset values, commands, sequencer states and the bus carrier.
  Assumes a 32-bit APB slave, one aligned word per register.
*/
package fsps_pkg;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;  // start bit, command, setup
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;  // end and error flags
  localparam logic [7:0]  ADDR_ADDR     = 8'h08;  // target flash address
  localparam logic [7:0]  ADDR_WDATA    = 8'h0c;  // write data
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_CMD_LO   = 1;
  localparam int          CTRL_FSET_LO  = 8;
  localparam int          ST_END        = 14;
  localparam int          ST_SEQUENCER_ERROR_FLAG      = 4;
  localparam int          ST_WRITE_CMD_ERROR_FLAG       = 1;
  localparam int          ST_ERASE_CMD_ERROR_FLAG       = 0;
  localparam logic [4:0]  FSET_RESET    = 5'h00;
  localparam int          DF_BLOCK_BYTES = 512;
  localparam logic [1:0]  CMD_WRITE     = 2'h0;
  localparam logic [1:0]  CMD_ERASE     = 2'h1;

  typedef enum logic [1:0] { fsps_idle, fsps_run, fsps_done } fsps_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } fsps_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fsps_apb_rsp_t;
endpackage : fsps_pkg

// ---- design/fsps_sequencer.sv ----
/*
  Flash self-program sequencer with its APB register file and the data flash
  array behind it.
  Register map, one aligned 32-bit word each:
    control : start bit, command code, frequency setting field
    status  : operation end flag and the three error flags, read only
    target  : flash byte address of the next write or erase
    wdata   : data byte for the next write
  Command codes other than write and erase end at once with a sequencer error.
  An erase that runs to its end, with no abort, covers the whole block that holds the target address.
  Assumes pclk at 10 MHz, presetn asynchronous active low, and a core that
  honours cpu_wait by halting, so no fetch or data access runs mid-rewrite.
*/
// Summary of operation
// - Setting the start bit runs the sequencer and holds the CPU in wait until it ends.
// - Software reads end flag and error flag after the wait, then clears the start bit.
// - During a rewrite the CPU is stopped and the region is not accessible.
// - Data flash erase clears one whole 512-byte block per operation.
// - CPU reads the data flash directly in 8-bit or 16-bit width.
// - No background operation: code fetch stalls for the whole rewrite.
// - Instruction fetches from the data flash are refused.
// - Data flash is readable right after reset with no register setup.
// - End flag is 0 while busy, 1 when ended, and 0 again once the start bit clears.
// - Sequencer and erase error flags set on error and clear at next activation.
// - Write error flag sets on a failed write and clears at next activation.
`timescale 1ns/1ps
module fsps_sequencer
  import fsps_pkg::*;
#(
  parameter int DF_BYTES = 2048,
  parameter int OP_CYCLES = 8
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire fsps_pkg::fsps_apb_req_t apb_req,
  output fsps_pkg::fsps_apb_rsp_t      apb_rsp,
  input  wire logic                    df_rd,
  input  wire logic                    df_wide,
  input  wire logic                    df_fetch,
  input  wire logic [15:0]             df_addr,
  input  wire logic                    fast_osc_stop_bit,
  output logic                         df_rvalid,
  output logic                         df_fetch_err,
  output logic [15:0]                  df_rdata,
  output logic                         cpu_wait,
  output logic                         fetch_stall
);
  import fsps_pkg::*;

  localparam int AW = $clog2(DF_BYTES);
  localparam int BW = $clog2(DF_BLOCK_BYTES);
  localparam int CW = $clog2(DF_BLOCK_BYTES + OP_CYCLES + 1);
  localparam int LANES = 2;

  typedef struct packed {
    fsps_state_t   st;
    logic          sequencer_start_bit;
    logic [1:0]    cmd;
    logic [4:0]    frequency_setting_field;
    logic [AW-1:0] tgt;
    logic [7:0]    wdata;
    logic          operation_end_flag;
    logic          sequencer_error_flag;
    logic          write_cmd_error_flag;
    logic          erase_cmd_error_flag;
    logic [CW-1:0] cnt;
    fsps_apb_rsp_t rsp;
    logic          df_rvalid;
    logic          df_fetch_err;
    logic [15:0]   df_rdata;
    logic          cpu_wait;
  } fsps_regs_t;

  fsps_regs_t       r;
  fsps_regs_t       next_r;
  logic [7:0]       mem [DF_BYTES] = '{default: 8'hff};
  logic [7:0]       lane_byte [LANES];
  logic             mem_we;
  logic [AW-1:0]    mem_wa;
  logic [7:0]       mem_wd;
  logic             acc;
  logic [31:0]      rd_word;
  logic [AW-1:0]    ra;

  assign acc = apb_req.psel && apb_req.penable;
  assign ra  = df_addr[AW-1:0];

  // One lane per byte of a wide read; lane 0 takes the even byte
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [AW-1:0] lane_addr;
    if (g == 0) begin : g_low
      assign lane_addr = df_wide ? (ra & ~AW'(1)) : ra;
    end else begin : g_high
      assign lane_addr = ra | AW'(1);
    end
    assign lane_byte[g] = mem[lane_addr];
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (apb_req.paddr)
      ADDR_CTRL: begin
        rd_word[CTRL_START] = r.sequencer_start_bit;
        rd_word[CTRL_CMD_LO +: 2] = r.cmd;
        rd_word[CTRL_FSET_LO +: 5] = r.frequency_setting_field;
      end
      ADDR_STATUS: begin
        rd_word[ST_END]   = r.operation_end_flag;
        rd_word[ST_SEQUENCER_ERROR_FLAG] = r.sequencer_error_flag;
        rd_word[ST_WRITE_CMD_ERROR_FLAG]  = r.write_cmd_error_flag;
        rd_word[ST_ERASE_CMD_ERROR_FLAG]  = r.erase_cmd_error_flag;
      end
      ADDR_ADDR:  rd_word[AW-1:0] = r.tgt;
      ADDR_WDATA: rd_word[7:0] = r.wdata;
      default:    rd_word = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_r = r;
    mem_we = 1'b0;
    mem_wa = r.tgt;
    mem_wd = r.wdata;
    next_r.rsp.pready  = acc && !r.rsp.pready;
    next_r.rsp.pslverr = 1'b0;
    next_r.rsp.prdata  = 32'h0000_0000;
    // Access taken in its first cycle; pready answers one cycle later
    if (acc && !r.rsp.pready) begin
      next_r.rsp.prdata = rd_word;
      if (!(apb_req.paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_ADDR, ADDR_WDATA})) begin
        next_r.rsp.pslverr = 1'b1;
      end
      if (apb_req.pwrite) begin
        case (apb_req.paddr)
          ADDR_CTRL: begin
            next_r.sequencer_start_bit = apb_req.pwdata[CTRL_START];
            if (r.st == fsps_idle) begin
              next_r.cmd = apb_req.pwdata[CTRL_CMD_LO +: 2];
              next_r.frequency_setting_field = apb_req.pwdata[CTRL_FSET_LO +: 5];
            end
          end
          // Target doubles as the erase cursor, so it is frozen while running
          ADDR_ADDR: begin
            if (r.st != fsps_run) begin
              next_r.tgt = apb_req.pwdata[AW-1:0];
            end
          end
          ADDR_WDATA: begin
            if (r.st != fsps_run) begin
              next_r.wdata = apb_req.pwdata[7:0];
            end
          end
          default:    next_r.rsp.pslverr = next_r.rsp.pslverr;
        endcase
      end
    end

    // Sequencer: started by a rising write of the start bit while idle
    case (r.st)
      fsps_idle: begin
        if (next_r.sequencer_start_bit && !r.sequencer_start_bit) begin
          next_r.st = fsps_run;
          next_r.cpu_wait = 1'b1;
          next_r.operation_end_flag = 1'b0;
          next_r.sequencer_error_flag = 1'b0;
          next_r.erase_cmd_error_flag = 1'b0;
          next_r.write_cmd_error_flag = 1'b0;
          // Erase walks the block a byte a cycle; a write takes a fixed time
          next_r.cnt = CW'(OP_CYCLES);
          if (next_r.cmd == CMD_ERASE) begin
            next_r.cnt = CW'(DF_BLOCK_BYTES);
            next_r.tgt = {next_r.tgt[AW-1:BW], BW'(0)};
          end
        end
      end
      fsps_run: begin
        if (!next_r.sequencer_start_bit) begin
          // Start dropped mid-rewrite: stop now, contents not trusted
          next_r.sequencer_error_flag = 1'b1;
          next_r.st = fsps_idle;
          next_r.cpu_wait = 1'b0;
          next_r.operation_end_flag = 1'b0;
        end else if (fast_osc_stop_bit) begin
          // Oscillator lost mid-operation: abort and flag it
          next_r.sequencer_error_flag = 1'b1;
          next_r.erase_cmd_error_flag = (r.cmd == CMD_ERASE);
          next_r.write_cmd_error_flag = (r.cmd == CMD_WRITE);
          next_r.st = fsps_done;
          next_r.cpu_wait = 1'b0;
          next_r.operation_end_flag = 1'b1;
        end else if (r.cmd != CMD_WRITE && r.cmd != CMD_ERASE) begin
          next_r.sequencer_error_flag = 1'b1;
          next_r.st = fsps_done;
          next_r.cpu_wait = 1'b0;
          next_r.operation_end_flag = 1'b1;
        end else if (r.cmd == CMD_ERASE) begin
          mem_we = 1'b1;
          mem_wd = 8'hff;
          next_r.tgt = r.tgt + AW'(1);
          next_r.cnt = r.cnt - CW'(1);
          if (r.cnt == CW'(1)) begin
            next_r.tgt = r.tgt - AW'(DF_BLOCK_BYTES - 1);
            next_r.st = fsps_done;
            next_r.cpu_wait = 1'b0;
            next_r.operation_end_flag = 1'b1;
          end
        end else begin
          next_r.cnt = r.cnt - CW'(1);
          if (r.cnt == CW'(1)) begin
            // Flash can only clear bits; a write needing a 0->1 fails
            if ((mem[r.tgt] & r.wdata) != r.wdata) begin
              next_r.write_cmd_error_flag = 1'b1;
              next_r.sequencer_error_flag = 1'b1;
            end else begin
              mem_we = 1'b1;
            end
            next_r.st = fsps_done;
            next_r.cpu_wait = 1'b0;
            next_r.operation_end_flag = 1'b1;
          end
        end
      end
      fsps_done: begin
        if (!next_r.sequencer_start_bit) begin
          next_r.st = fsps_idle;
          next_r.operation_end_flag = 1'b0;
        end
      end
      default: next_r.st = fsps_idle;
    endcase

    // Reads blocked while a rewrite owns the array
    next_r.df_rvalid = df_rd && !df_fetch && !r.cpu_wait;
    next_r.df_fetch_err = df_rd && df_fetch;
    next_r.df_rdata = 16'h0000;
    if (df_rd && !df_fetch && !r.cpu_wait) begin
      next_r.df_rdata[7:0] = lane_byte[0];
      if (df_wide) begin
        next_r.df_rdata[15:8] = lane_byte[1];
      end
    end
  end

  // Single write port: an erase clears one byte per cycle
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.frequency_setting_field <= FSET_RESET;
      r.st <= fsps_idle;
    end else begin
      r <= next_r;
    end
  end

  assign apb_rsp      = r.rsp;
  assign df_rvalid    = r.df_rvalid;
  assign df_fetch_err = r.df_fetch_err;
  assign df_rdata     = r.df_rdata;
  assign cpu_wait     = r.cpu_wait;
  assign fetch_stall  = r.cpu_wait;
endmodule : fsps_sequencer

// ---- verification/fsps_monitor.sv ----
/* Checker on the sequencer ports.
   Assumes the APB master holds each request until pready. */
`timescale 1ns/1ps
module fsps_monitor
  import fsps_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire fsps_pkg::fsps_apb_req_t apb_req,
  input wire fsps_pkg::fsps_apb_rsp_t apb_rsp,
  input wire logic                    df_rd,
  input wire logic                    df_fetch,
  input wire logic                    df_rvalid,
  input wire logic                    df_fetch_err,
  input wire logic [15:0]             df_rdata,
  input wire logic                    cpu_wait,
  input wire logic                    fetch_stall
);
  import fsps_pkg::*;
  logic take;
  logic start_q;
  logic ctrl_wr;
  assign take = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  assign ctrl_wr = take && apb_req.pwrite && apb_req.paddr == ADDR_CTRL;
  // Start bit as last written; the end flag may only show while it is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else if (ctrl_wr) begin
      start_q <= apb_req.pwdata[CTRL_START];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_STALL: assert property (fetch_stall == cpu_wait)
    else $error("fetch stall differs from wait");
  AST_START_WAIT: assert property (ctrl_wr && apb_req.pwdata[0] && !start_q |=> cpu_wait)
    else $error("start did not hold the cpu");
  AST_WAIT_ENDS: assert property ($rose(cpu_wait) |-> ##[1:600] !cpu_wait)
    else $error("cpu wait never released");
  AST_READ_BLOCKED: assert property (cpu_wait && df_rd |=> !df_rvalid)
    else $error("flash read served during rewrite");
  AST_FETCH_REFUSED: assert property (df_rd && df_fetch && !cpu_wait |=> df_fetch_err && !df_rvalid)
    else $error("fetch from data flash not refused");
  AST_READ_SERVED: assert property (df_rd && !df_fetch && !cpu_wait |=> df_rvalid)
    else $error("data flash read not served");
  AST_RDATA_IDLE: assert property (!df_rvalid |-> df_rdata == 16'h0000)
    else $error("read data outside valid");
  AST_END_BUSY: assert property (apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == ADDR_STATUS
    && !start_q |-> !apb_rsp.prdata[ST_END])
    else $error("end flag set with start clear");
  AST_ACCESS: assert property (take |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("access not answered once");
  cover property ($fell(cpu_wait));
  cover property (df_fetch_err);
  cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule : fsps_monitor
bind fsps_sequencer fsps_monitor mon (.*);

// ---- verification/fsps_cpu_model.sv ----
/* CPU running self-programming code from code flash.
   Waits for every APB answer as long as it takes; the bench watchdog ends a hang. */
`timescale 1ns/1ps
module fsps_cpu_model
  import fsps_pkg::*;
(
  input  wire logic                    pclk,
  output fsps_pkg::fsps_apb_req_t      apb_req,
  input  wire fsps_pkg::fsps_apb_rsp_t apb_rsp,
  output logic                         df_rd,
  output logic                         df_wide,
  output logic                         df_fetch,
  output logic [15:0]                  df_addr,
  input  wire logic                    df_rvalid,
  input  wire logic                    df_fetch_err,
  input  wire logic [15:0]             df_rdata
);
  import fsps_pkg::*;
  initial begin
    apb_req = '0;
    {df_rd, df_wide, df_fetch, df_addr} = '0;
  end
  // Only setup steps, issued with interrupts held off, never to its own block
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    // Released lines show the inverse, never a stale copy
    apb_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic w, input logic f,
                    output logic [15:0] q, output logic ok, output logic fe);
    @(posedge pclk);
    {df_rd, df_wide, df_fetch, df_addr} <= {1'b1, w, f, a};
    @(posedge pclk);
    df_rd <= 1'b0;
    df_addr <= ~a;
    @(posedge pclk);
    q = df_rdata;
    ok = df_rvalid;
    fe = df_fetch_err;
  endtask : rd
endmodule : fsps_cpu_model

// ---- verification/tb_flash_self_program_sequencer.sv ----
/* Testbench for the sequencer.
   Assumes the CPU model in fsps_cpu_model and the bound checker. */
`timescale 1ns/1ps
module tb_flash_self_program_sequencer;
  import fsps_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [7:0]  d;
    logic [1:0]  c;
    logic [9:0]  cyc;
    logic [15:0] st;
    logic [15:0] ra;
    logic        rw;
    logic [15:0] rx;
  } fsps_row_t;
  // Frequency code assumed for a 10 MHz clock
  localparam logic [31:0] FSET = 32'h0000_0900;
  localparam fsps_row_t ROWS [6] = '{
    '{16'h0010, 8'h5a, CMD_WRITE, 10'd8, 16'h4000, 16'h0010, 1'b0, 16'h005a},
    '{16'h0011, 8'h3c, CMD_WRITE, 10'd8, 16'h4000, 16'h0010, 1'b1, 16'h3c5a},
    '{16'h0200, 8'h00, CMD_WRITE, 10'd8, 16'h4000, 16'h0200, 1'b0, 16'h0000},
    '{16'h0010, 8'hff, CMD_WRITE, 10'd0, 16'h4012, 16'h0010, 1'b0, 16'h005a},
    '{16'h0015, 8'h00, CMD_ERASE, 10'd512, 16'h4000, 16'h0010, 1'b1, 16'hffff},
    '{16'h0000, 8'h00, 2'h2, 10'd0, 16'h4010, 16'h0200, 1'b0, 16'h0000}};
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          osc = 1'b0;
  fsps_apb_req_t req;
  fsps_apb_rsp_t rsp;
  logic          df_rd, df_wide, df_fetch, df_rvalid, df_fetch_err, cpu_wait, fetch_stall;
  logic [15:0]   df_addr, df_rdata;
  int            err_total = 0;
  int            comparisons = 0;
  always #50 pclk = ~pclk;
  fsps_sequencer #(.DF_BYTES(2048), .OP_CYCLES(8)) dut (.pclk, .presetn, .apb_req(req),
    .apb_rsp(rsp), .df_rd, .df_wide, .df_fetch, .df_addr, .fast_osc_stop_bit(osc),
    .df_rvalid, .df_fetch_err, .df_rdata, .cpu_wait, .fetch_stall);
  fsps_cpu_model cpu (.pclk, .apb_req(req), .apb_rsp(rsp), .df_rd, .df_wide, .df_fetch,
    .df_addr, .df_rvalid, .df_fetch_err, .df_rdata);
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  task automatic status(input logic [15:0] x, input logic [15:0] k);
    logic [31:0] q;
    logic e;
    cpu.apb(1'b0, ADDR_STATUS, 32'h0, q, e);
    check("status", q & {16'h0, k}, {16'h0, x});
  endtask : status
  task automatic run(input logic [15:0] a, input logic [7:0] d, input logic [1:0] c,
                     input int m, output int n);
    logic [31:0] q;
    logic e, ok, fe;
    logic [15:0] dq;
    cpu.apb(1'b1, ADDR_ADDR, {16'h0, a}, q, e);
    cpu.apb(1'b1, ADDR_WDATA, {24'h0, d}, q, e);
    cpu.apb(1'b1, ADDR_CTRL, FSET | {29'h0, c, 1'b1}, q, e);
    if (m == 1) begin
      cpu.rd(16'h0010, 1'b1, 1'b0, dq, ok, fe);
      check("read in wait", {31'h0, ok}, 32'h0);
    end
    if (m == 2) begin
      osc <= 1'b1;
    end
    if (m == 3) begin
      cpu.apb(1'b1, ADDR_CTRL, FSET, q, e);
    end
    n = 0;
    while (cpu_wait !== 1'b0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check("wait released", {31'h0, cpu_wait}, 32'h0);
  endtask : run
  initial begin
    #2_000_000;
    err_total++;
    test_done();
  end
  initial begin
    fsps_row_t r;
    logic [31:0] q;
    logic e, ok, fe;
    logic [15:0] dq;
    int n;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      r = ROWS[i];
      run(r.a, r.d, r.c, 0, n);
      if (r.cyc != 0) check("busy cycles", n, 32'(r.cyc));
      status(r.st, 16'hffff);
      cpu.apb(1'b1, ADDR_CTRL, FSET, q, e);
      status(r.st & 16'hbfff, 16'hffff);
      cpu.rd(r.ra, r.rw, 1'b0, dq, ok, fe);
      check("flash data", r.rw ? dq : {8'h0, dq[7:0]}, r.rx);
    end
    run(16'h0200, 8'h00, CMD_ERASE, 1, n);
    cpu.apb(1'b1, ADDR_CTRL, FSET, q, e);
    run(16'h0020, 8'h00, CMD_WRITE, 2, n);
    osc <= 1'b0;
    status(16'h0012, 16'h0013);
    cpu.apb(1'b1, ADDR_CTRL, FSET, q, e);
    // 30 us at 100 ns before any further rewrite
    repeat (300) @(posedge pclk);
    run(16'h0400, 8'h00, CMD_ERASE, 3, n);
    status(16'h0010, 16'h4011);
    cpu.rd(16'h0010, 1'b0, 1'b1, dq, ok, fe);
    check("fetch refused", {30'h0, ok, fe}, 32'h1);
    cpu.apb(1'b0, 8'h40, 32'h0, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    status(16'h0000, 16'hffff);
    cpu.rd(16'h0300, 1'b1, 1'b0, dq, ok, fe);
    check("read after reset", {15'h0, ok, dq}, 32'h0001_ffff);
    test_done();
  end
endmodule : tb_flash_self_program_sequencer
